/* fsc_pkg.sv */
// Package of constants and types for the flash command controller.
package fsc_pkg;
    localparam int          CLK_HZ             = 20_000_000;
    localparam int          SUSP_ERASE_US      = 15;
    localparam int          SUSP_PROG_US       = 20;
    localparam int          POWER_ON_MS        = 10;
    localparam int          SUSP_ERASE_CYC     = SUSP_ERASE_US * (CLK_HZ / 1_000_000);
    localparam int          SUSP_PROG_CYC      = SUSP_PROG_US * (CLK_HZ / 1_000_000);
    localparam int          POWER_ON_CYC       = POWER_ON_MS * (CLK_HZ / 1000);
    localparam int          WR_PHASE_CYC       = 2;
    localparam int          RD_PHASE_CYC       = 3;
    localparam logic [11:0] ADR_UNLOCK1        = 12'h0555;
    localparam logic [11:0] ADR_UNLOCK2        = 12'h0aaa;
    localparam logic [11:0] ADR_CFI            = 12'h0055;
    localparam logic [11:0] ADR_SEC_LOCK       = 12'h0080;
    localparam logic [7:0]  DAT_UNLOCK1        = 8'h00aa;
    localparam logic [7:0]  DAT_UNLOCK2        = 8'h0055;
    localparam logic [7:0]  CMD_SUSPEND        = 8'h00b0;
    localparam logic [7:0]  CMD_RESUME         = 8'h0030;
    localparam logic [7:0]  CMD_IDENT_ENTRY    = 8'h0090;
    localparam logic [7:0]  CMD_IDENT_EXIT     = 8'h00f0;
    localparam logic [7:0]  CMD_SEC_PROG       = 8'h00c0;
    localparam logic [7:0]  CMD_CFI            = 8'h0098;
    localparam logic [7:0]  CMD_PROG           = 8'h00a0;
    localparam logic [7:0]  DAT_SEC_LOCK       = 8'h00fd;
    localparam int          LOCK_FLAG_BIT      = 1;
    localparam int          POLL_STATUS_BIT    = 7;
    localparam int          TOGGLE_STATUS_BIT  = 6;
    localparam int          FAIL_STATUS_BIT    = 5;
    localparam logic [3:0]  REG_CTRL           = 4'h0;
    localparam logic [3:0]  REG_ADDR           = 4'h1;
    localparam logic [3:0]  REG_DATA           = 4'h2;
    localparam logic [3:0]  REG_STAT           = 4'h3;
    localparam logic [3:0]  REG_RDATA          = 4'h4;
    localparam logic [3:0]  OP_READ            = 4'h1;
    localparam logic [3:0]  OP_PROG            = 4'h2;
    localparam logic [3:0]  OP_SUSPEND         = 4'h3;
    localparam logic [3:0]  OP_RESUME          = 4'h4;
    localparam logic [3:0]  OP_IDENT_ENTRY     = 4'h5;
    localparam logic [3:0]  OP_IDENT_EXIT      = 4'h6;
    localparam logic [3:0]  OP_SEC_PROG        = 4'h7;
    localparam logic [3:0]  OP_SEC_LOCK        = 4'h8;
    localparam logic [3:0]  OP_SEC_STATUS      = 4'h9;
    localparam logic [3:0]  OP_CFI             = 4'h0a;
    localparam logic [3:0]  OP_POLL            = 4'h0b;
    localparam logic [15:0] DATA_RESET         = 16'h0000;
    typedef enum logic [1:0] {FSC_STEP_WRITE, FSC_STEP_READ} fsc_step_e;
endpackage

/* fsc_bus_if.sv */
// Interface between the sequencer and the pin cycle engine.
`timescale 1ns/10ps
interface fsc_bus_if;
    logic       start;
    logic       is_read;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic       done;
    logic [15:0] rdata;
    modport seq (output start, output is_read, output addr, output wdata,
                 input done, input rdata);
    modport eng (input start, input is_read, input addr, input wdata,
                 output done, output rdata);
endinterface

/* fsc_cycle.sv */
// Pin cycle engine: one write or read bus cycle on the flash strobes.
`timescale 1ns/10ps
module fsc_cycle
(
    input  wire logic  mclk,
    input  wire logic  rst_n,
    fsc_bus_if.eng     bus,
    output logic       ce_n,
    output logic       oe_n,
    output logic       we_n,
    output logic [19:0] addr,
    output logic [15:0] dq_o,
    output logic       dq_oe,
    input  wire logic [15:0] dq_i
);
    typedef enum logic [1:0] {FSC_IDLE, FSC_ACT, FSC_END} fsc_cyc_e;
    fsc_cyc_e    st_q, st_d;
    logic [2:0]  cnt_q, cnt_d;
    logic        rd_q, rd_d;
    logic        done_q, done_d;
    logic [15:0] rdata_q, rdata_d;
    logic        ce_d, oe_d, we_d, oen_d;
    logic [19:0] addr_d;
    logic [15:0] dqo_d;
    always_comb
    begin
        st_d = st_q; cnt_d = cnt_q; rd_d = rd_q; done_d = 1'b0;
        rdata_d = rdata_q; ce_d = ce_n; oe_d = oe_n; we_d = we_n;
        oen_d = dq_oe; addr_d = addr; dqo_d = dq_o;
        case (st_q)
            FSC_IDLE:
            begin
                if (bus.start)
                begin
                    st_d = FSC_ACT; rd_d = bus.is_read;
                    addr_d = bus.addr; dqo_d = bus.wdata;
                    ce_d = 1'b0; oe_d = !bus.is_read;
                    // OE high, CE low and WE low so a program cycle can start.
                    we_d = bus.is_read; oen_d = !bus.is_read;
                    cnt_d = bus.is_read ? 3'(fsc_pkg::RD_PHASE_CYC)
                                        : 3'(fsc_pkg::WR_PHASE_CYC);
                end
            end
            FSC_ACT:
            begin
                if (cnt_q == 3'h1)
                begin
                    st_d = FSC_END;
                    if (rd_q) rdata_d = dq_i;
                    // Chip enable stays low one cycle past the strobes.
                    oe_d = 1'b1; we_d = 1'b1;
                end
                else cnt_d = cnt_q - 3'h1;
            end
            FSC_END:
            begin
                ce_d = 1'b1; oen_d = 1'b0; done_d = 1'b1; st_d = FSC_IDLE;
            end
            default: st_d = FSC_IDLE;
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= FSC_IDLE; cnt_q <= 3'h0; rd_q <= 1'b0; done_q <= 1'b0;
            rdata_q <= 16'h0000; ce_n <= 1'b1; oe_n <= 1'b1; we_n <= 1'b1;
            dq_oe <= 1'b0; addr <= 20'h0_0000; dq_o <= 16'h0000;
        end
        else
        begin
            st_q <= st_d; cnt_q <= cnt_d; rd_q <= rd_d; done_q <= done_d;
            rdata_q <= rdata_d; ce_n <= ce_d; oe_n <= oe_d; we_n <= we_d;
            dq_oe <= oen_d; addr <= addr_d; dq_o <= dqo_d;
        end
    end
    assign bus.done  = done_q;
    assign bus.rdata = rdata_q;
    a_we_oe_excl: assert property (@(posedge mclk) disable iff (!rst_n)
        !we_n |-> (oe_n && !ce_n)) else $error("write strobe with oe low");
endmodule

/* fsc_top.sv */
// Host controller that sequences flash commands from software orders.
`timescale 1ns/10ps
module fsc_top
#(
    parameter int POWER_ON_CYC = fsc_pkg::POWER_ON_CYC
)
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  sw_addr,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [31:0]      sw_rdata,
    output logic             fl_ce_n,
    output logic             fl_oe_n,
    output logic             fl_we_n,
    output logic [19:0]      fl_addr,
    output logic [15:0]      fl_dq_o,
    output logic             fl_dq_oe,
    input  wire logic [15:0] fl_dq_i,
    input  wire logic        fl_ready_i,
    input  wire logic        power_good
);
    typedef enum logic [2:0] {FSC_IDLE, FSC_ISSUE, FSC_WAIT, FSC_HOLD,
                              FSC_POLL} fsc_st_e;
    fsc_bus_if bus();
    fsc_cycle u_cycle (.mclk(mclk), .rst_n(rst_n), .bus(bus),
        .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .addr(fl_addr),
        .dq_o(fl_dq_o), .dq_oe(fl_dq_oe), .dq_i(fl_dq_i));

    // ------------------------------------------------------------
    // Command step table.
    // ------------------------------------------------------------
    function automatic logic [2:0] op_len(input logic [3:0] op);
        case (op)
            fsc_pkg::OP_READ, fsc_pkg::OP_SUSPEND, fsc_pkg::OP_RESUME,
            fsc_pkg::OP_IDENT_EXIT, fsc_pkg::OP_CFI,
            fsc_pkg::OP_POLL:                          op_len = 3'h1;
            fsc_pkg::OP_IDENT_ENTRY:                   op_len = 3'h3;
            default:                                   op_len = 3'h4;
        endcase
    endfunction

    logic [3:0]  op_q, op_d;
    logic [19:0] adr_q, adr_d;
    logic [15:0] dat_q, dat_d;
    logic [15:0] rd_q, rd_d;
    logic [2:0]  step_q, step_d;
    fsc_st_e     st_q, st_d;
    logic [17:0] tmr_q, tmr_d;
    logic [17:0] pwr_q, pwr_d;
    logic        busy_q, busy_d, err_q, err_d, ident_q, ident_d;
    logic        cfi_q, cfi_d, esusp_q, esusp_d, locked_q, locked_d;
    logic        tog_q, tog_d, fail_q, fail_d;
    logic        go;
    logic [19:0] c_adr;
    logic [15:0] c_dat;
    logic        c_rd;

    // ------------------------------------------------------------
    // Step encoder: address and data of each bus cycle.
    // ------------------------------------------------------------
    always_comb
    begin
        c_rd = 1'b0;
        c_adr = {8'h00, fsc_pkg::ADR_UNLOCK1};
        c_dat = {8'h00, fsc_pkg::DAT_UNLOCK1};
        if (step_q == 3'h1 && op_len(op_q) != 3'h1)
        begin
            c_adr = {8'h00, fsc_pkg::ADR_UNLOCK2};
            c_dat = {8'h00, fsc_pkg::DAT_UNLOCK2};
        end
        else if (step_q == 3'h2)
        begin
            case (op_q)
                fsc_pkg::OP_PROG: c_dat = {8'h00, fsc_pkg::CMD_PROG};
                fsc_pkg::OP_SEC_PROG, fsc_pkg::OP_SEC_LOCK:
                    c_dat = {8'h00, fsc_pkg::CMD_SEC_PROG};
                default: c_dat = {8'h00, fsc_pkg::CMD_IDENT_ENTRY};
            endcase
        end
        else if (op_len(op_q) == 3'h1 || step_q == 3'h3)
        begin
            c_adr = adr_q;
            c_dat = dat_q;
            case (op_q)
                fsc_pkg::OP_READ, fsc_pkg::OP_POLL: c_rd = 1'b1;
                fsc_pkg::OP_SUSPEND:
                begin
                    c_adr = 20'h0_0000;
                    c_dat = {8'h00, fsc_pkg::CMD_SUSPEND};
                end
                fsc_pkg::OP_RESUME:
                begin
                    c_adr = 20'h0_0000;
                    c_dat = {8'h00, fsc_pkg::CMD_RESUME};
                end
                fsc_pkg::OP_IDENT_EXIT:
                begin
                    c_adr = 20'h0_0000;
                    c_dat = {8'h00, fsc_pkg::CMD_IDENT_EXIT};
                end
                fsc_pkg::OP_CFI:
                begin
                    c_adr = {8'h00, fsc_pkg::ADR_CFI};
                    c_dat = {8'h00, fsc_pkg::CMD_CFI};
                end
                fsc_pkg::OP_SEC_LOCK:
                begin
                    c_adr = {8'h00, fsc_pkg::ADR_SEC_LOCK};
                    c_dat = {8'h00, fsc_pkg::DAT_SEC_LOCK};
                end
                fsc_pkg::OP_SEC_STATUS:
                begin
                    c_adr = {8'h00, fsc_pkg::ADR_SEC_LOCK};
                    c_rd = 1'b1;
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Order decode, sequencing and status.
    // ------------------------------------------------------------
    always_comb
    begin
        op_d = op_q; adr_d = adr_q; dat_d = dat_q; rd_d = rd_q;
        step_d = step_q; st_d = st_q; tmr_d = tmr_q; err_d = err_q;
        busy_d = busy_q; ident_d = ident_q; cfi_d = cfi_q;
        esusp_d = esusp_q; locked_d = locked_q; tog_d = tog_q;
        fail_d = fail_q;
        pwr_d = pwr_q;
        if (!power_good) pwr_d = 18'(POWER_ON_CYC);
        else if (pwr_q != 18'h0_0000) pwr_d = pwr_q - 18'h0_0001;
        go = sw_wr && sw_addr == fsc_pkg::REG_CTRL && !busy_q;
        if (sw_wr && sw_addr == fsc_pkg::REG_ADDR) adr_d = sw_wdata[19:0];
        if (sw_wr && sw_addr == fsc_pkg::REG_DATA) dat_d = sw_wdata[15:0];
        if (go)
        begin
            err_d = 1'b0;
            op_d = sw_wdata[3:0];
            // Programs before the power-on delay, and ops other than read, security status,
            // CFI and ident exit after an ident entry or security access without ident exit or CFI entry, are refused.
            if (((sw_wdata[3:0] == fsc_pkg::OP_PROG ||
                  sw_wdata[3:0] == fsc_pkg::OP_SEC_PROG) &&
                 pwr_q != 18'h0_0000) ||
                (ident_q && !cfi_q && sw_wdata[3:0] != fsc_pkg::OP_READ &&
                 sw_wdata[3:0] != fsc_pkg::OP_IDENT_EXIT &&
                 sw_wdata[3:0] != fsc_pkg::OP_SEC_STATUS &&
                 sw_wdata[3:0] != fsc_pkg::OP_CFI) ||
                (sw_wdata[3:0] == fsc_pkg::OP_SEC_PROG && locked_q))
                err_d = 1'b1;
            else
            begin
                busy_d = 1'b1; step_d = 3'h0; st_d = FSC_ISSUE;
            end
        end
        case (st_q)
            FSC_IDLE: ;
            FSC_ISSUE: st_d = FSC_WAIT;
            FSC_WAIT:
            begin
                if (bus.done)
                begin
                    if (c_rd) rd_d = bus.rdata;
                    if (step_q + 3'h1 != op_len(op_q))
                    begin
                        step_d = step_q + 3'h1; st_d = FSC_ISSUE;
                    end
                    else
                    begin
                        st_d = FSC_IDLE; busy_d = 1'b0;
                        case (op_q)
                            fsc_pkg::OP_SUSPEND:
                            begin
                                esusp_d = 1'b1;
                                // Wait the longer of the two halt times.
                                tmr_d = 18'(fsc_pkg::SUSP_PROG_CYC);
                                st_d = FSC_HOLD; busy_d = 1'b1;
                            end
                            fsc_pkg::OP_RESUME: esusp_d = 1'b0;
                            fsc_pkg::OP_IDENT_ENTRY,
                            fsc_pkg::OP_SEC_STATUS: ident_d = 1'b1;
                            fsc_pkg::OP_IDENT_EXIT:
                            begin
                                ident_d = 1'b0; cfi_d = 1'b0;
                            end
                            fsc_pkg::OP_CFI:
                            begin
                                cfi_d = 1'b1; ident_d = 1'b1;
                            end
                            fsc_pkg::OP_SEC_LOCK: locked_d = 1'b1;
                            fsc_pkg::OP_POLL:
                            begin
                                // A fail seen while fail_q is clear forces one more read.
                                fail_d = bus.rdata[fsc_pkg::FAIL_STATUS_BIT];
                                tog_d = bus.rdata[fsc_pkg::TOGGLE_STATUS_BIT];
                                if (bus.rdata[fsc_pkg::FAIL_STATUS_BIT] &&
                                    !fail_q)
                                begin
                                    st_d = FSC_ISSUE; busy_d = 1'b1;
                                    step_d = 3'h0;
                                end
                            end
                            default: ;
                        endcase
                        if (op_q == fsc_pkg::OP_SEC_STATUS)
                            locked_d = !bus.rdata[fsc_pkg::LOCK_FLAG_BIT];
                    end
                end
            end
            FSC_HOLD:
            begin
                if (tmr_q == 18'h0_0001)
                begin
                    st_d = FSC_IDLE; busy_d = 1'b0;
                end
                tmr_d = tmr_q - 18'h0_0001;
            end
            default: st_d = FSC_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_q <= 4'h0; adr_q <= 20'h0_0000; dat_q <= fsc_pkg::DATA_RESET;
            rd_q <= 16'h0000; step_q <= 3'h0; st_q <= FSC_IDLE;
            tmr_q <= 18'h0_0000; pwr_q <= 18'(POWER_ON_CYC);
            busy_q <= 1'b0; err_q <= 1'b0; ident_q <= 1'b0; cfi_q <= 1'b0;
            esusp_q <= 1'b0; locked_q <= 1'b0; tog_q <= 1'b0;
            fail_q <= 1'b0; sw_rdata <= 32'h0000_0000;
        end
        else
        begin
            op_q <= op_d; adr_q <= adr_d; dat_q <= dat_d; rd_q <= rd_d;
            step_q <= step_d; st_q <= st_d; tmr_q <= tmr_d;
            pwr_q <= pwr_d; busy_q <= busy_d; err_q <= err_d;
            ident_q <= ident_d; cfi_q <= cfi_d; esusp_q <= esusp_d;
            locked_q <= locked_d; tog_q <= tog_d; fail_q <= fail_d;
            if (sw_rd)
                case (sw_addr)
                    fsc_pkg::REG_ADDR: sw_rdata <= {12'h000, adr_q};
                    fsc_pkg::REG_DATA: sw_rdata <= {16'h0000, dat_q};
                    fsc_pkg::REG_STAT: sw_rdata <= {22'h00_0000,
                        pwr_q == 18'h0_0000, !fl_ready_i, fail_q, tog_q,
                        locked_q, esusp_q, cfi_q, ident_q, err_q,
                        busy_q};
                    fsc_pkg::REG_RDATA: sw_rdata <= {16'h0000, rd_q};
                    default: sw_rdata <= 32'h0000_0000;
                endcase
            else
                sw_rdata <= 32'h0000_0000;
        end
    end

    assign bus.start   = (st_q == FSC_ISSUE);
    assign bus.is_read = c_rd;
    assign bus.addr    = c_adr;
    assign bus.wdata   = c_dat;

    sequence s_susp_done;
        st_q == FSC_WAIT && bus.done && op_q == fsc_pkg::OP_SUSPEND &&
        step_q == 3'h0;
    endsequence
    a_susp_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        s_susp_done |=> busy_q [*8])
        else $error("suspend wait ended early");
    a_susp_noaddr: assert property (@(posedge mclk) disable iff (!rst_n)
        (bus.start && op_q == fsc_pkg::OP_SUSPEND) |->
        bus.addr == 20'h0_0000) else $error("suspend with address");
    a_cfi_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
        (bus.start && op_q == fsc_pkg::OP_CFI) |->
        bus.wdata[7:0] == 8'h98 && bus.addr[11:0] == 12'h055)
        else $error("cfi entry wrong");
    a_prog_pwr: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && sw_wdata[3:0] == fsc_pkg::OP_PROG && pwr_q != 18'h0_0000)
        |=> err_q && !busy_q) else $error("program before power delay");
    a_lock_d1: assert property (@(posedge mclk) disable iff (!rst_n)
        (bus.start && op_q == fsc_pkg::OP_SEC_LOCK && step_q == 3'h3) |->
        !bus.wdata[1]) else $error("lock bit not low");
    a_sec_refuse: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && locked_q && sw_wdata[3:0] == fsc_pkg::OP_SEC_PROG) |=>
        err_q) else $error("locked program accepted");
    a_exit_cfi: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(cfi_q) |-> $past(op_q) == fsc_pkg::OP_IDENT_EXIT)
        else $error("cfi left wrongly");
    a_resume_one: assert property (@(posedge mclk) disable iff (!rst_n)
        (bus.start && op_q == fsc_pkg::OP_RESUME) |->
        bus.wdata[7:0] == 8'h30 && step_q == 3'h0)
        else $error("resume not single");
endmodule

/* fsc_flash_model.sv */
// Behavioural model of the parallel flash device.
`timescale 1ns/10ps
module fsc_flash_model
#(
    parameter int          PON = 10,
    parameter int          PGM = 3000,
    parameter logic [15:0] IDC = 16'h0042
)
(
    input  wire logic        mclk,
    input  wire logic        pg,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [19:0] a,
    input  wire logic [15:0] di,
    output logic [15:0]      dout,
    output logic             ready
);
    // IDC is an arbitrary identification value.
    logic [15:0] mem [int];
    logic [15:0] last = 16'h0000;
    logic        sus = 0, idm = 0, cfi = 0, lck = 0, tog = 0;
    int          ul = 0, pon = 0, bsy = 0, pend = 0;
    function automatic logic [15:0] arr(logic [19:0] x);
        return mem.exists(x) ? mem[x] : x[15:0] ^ 16'hc3a5;
    endfunction
    function automatic logic [15:0] rd(logic [19:0] x);
        if (idm && x[11:0] == 12'h080) return {14'h0000, !lck, 1'b0};
        if (idm) return IDC;
        if (cfi) return {8'h00, x[7:0]};
        return arr(x);
    endfunction
    assign ready = bsy == 0 || sus;
    assign dout = ce_n || oe_n ? ~last
                : bsy > 0 && !sus ? {9'h000, tog, 6'h00} : rd(a);
    always @(posedge mclk)
    begin
        if (!ce_n && !oe_n) last <= dout;
        if (pg && pon < PON) pon++;
        if (bsy > 0 && !sus) bsy--;
    end
    always @(posedge oe_n) if (bsy > 0 && !sus) tog = !tog;
    always @(posedge we_n)
    begin
        if (!ce_n && oe_n)
        begin
            if (pend == 1)
            begin
                if (pon >= PON && bsy == 0)
                begin
                    mem[a] = arr(a) & di;
                    bsy = PGM;
                end
            end
            else if (pend == 2) lck |= a[11:0] == 12'h080 && !di[1];
            else if (di[7:0] == 8'hb0) sus = bsy > 0;
            else if (di[7:0] == 8'h30) sus = 0;
            else if (di[7:0] == 8'h98 && a[11:0] == 12'h055) cfi = bsy == 0;
            else if (ul == 2 && di[7:0] == 8'h90) idm = 1;
            else if (di[7:0] == 8'hf0 || ul != 2 && di[7:0] != 8'haa
                     && di[7:0] != 8'h55) {idm, cfi} = 2'b00;
            pend = ul == 2 && di[7:0] == 8'ha0 ? 1 : ul == 2 && di[7:0] == 8'hc0 ? 2 : 0;
            ul = di[7:0] == 8'haa && a[11:0] == 12'h555 ? 1 : ul == 1 && di[7:0] == 8'h55 ? 2 : 0;
        end
    end
endmodule

/* tb_flash_suspend_secid_cfi_control.sv */
// Self-checking testbench for the flash command controller.
`timescale 1ns/10ps
module tb_flash_suspend_secid_cfi_control;
    logic        mclk = 0, rst_n = 0, sw_wr = 0, sw_rd = 0, pg = 0;
    logic        ce_n, oe_n, we_n, dq_oe, rdy;
    logic [3:0]  sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0000_0000, sw_rdata, d;
    logic [19:0] fa, la, a;
    logic [15:0] dq_o, dq_i, fo, ld, v;
    int          failures = 0, compares = 0, nw = 0, n, m;
    int          seed = 32'he3d2a98a;
    fsc_top #(.POWER_ON_CYC(10)) i_dut (.mclk(mclk), .rst_n(rst_n),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n),
        .fl_addr(fa), .fl_dq_o(dq_o), .fl_dq_oe(dq_oe), .fl_dq_i(dq_i),
        .fl_ready_i(rdy), .power_good(pg));
    fsc_flash_model i_mem (.mclk(mclk), .pg(pg), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .a(fa), .di(dq_o), .dout(fo), .ready(rdy));
    assign dq_i = dq_oe ? dq_o : fo;
    initial forever #25 mclk = !mclk;
    always @(posedge we_n) if (!ce_n) {la, ld, nw} = {fa, dq_o, nw + 1};
    task automatic end_of_test();
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) failures++;
        if (s !== e) $display("Error %s expected %h seen %h", nm, e, s);
    endtask
    task automatic wr(logic [3:0] ad, logic [31:0] dt);
        @(posedge mclk);
        {sw_wr, sw_addr, sw_wdata} <= {1'b1, ad, dt};
        @(posedge mclk);
        sw_wr <= 0;
    endtask
    task automatic rd(logic [3:0] ad);
        @(posedge mclk);
        {sw_rd, sw_addr} <= {1'b1, ad};
        @(posedge mclk);
        sw_rd <= 0;
        #1 d = sw_rdata;
    endtask
    task automatic op(logic [3:0] o, logic [19:0] ad, logic [15:0] dt);
        wr(fsc_pkg::REG_ADDR, {12'h000, ad});
        wr(fsc_pkg::REG_DATA, {16'h0000, dt});
        m = nw;
        wr(fsc_pkg::REG_CTRL, {28'h0000_000, o});
        n = 0;
        do
        begin
            rd(fsc_pkg::REG_STAT);
            n++;
        end while (d[0] !== 1'b0 && n < 5000);
        if (d[0] !== 1'b0) failures++;
        if (d[0] !== 1'b0) end_of_test();
        rd(fsc_pkg::REG_STAT);
    endtask
    task automatic pol(logic [19:0] ad);
        logic b, t;
        int   j;
        b = 1'b0;
        t = 1'b0;
        j = 0;
        do
        begin
            op(fsc_pkg::OP_POLL, ad, 16'h0000);
            if (b && d[8]) chk("toggle", d[6], !t);
            b = d[8];
            t = d[6];
            j++;
        end while (d[8] !== 1'b0 && j < 1000);
        if (d[8] !== 1'b0) failures++;
        if (d[8] !== 1'b0) end_of_test();
    endtask
    task automatic prg(logic [19:0] ad, logic [15:0] dt);
        op(fsc_pkg::OP_PROG, ad, dt);
        pol(ad);
        op(fsc_pkg::OP_READ, ad, 16'h0000);
        rd(fsc_pkg::REG_RDATA);
        chk("prog", d[15:0], dt & (ad[15:0] ^ 16'hc3a5));
    endtask
    initial
    begin
        repeat (100000) @(posedge mclk);
        failures++;
        end_of_test();
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        rst_n <= 1;
        op(fsc_pkg::OP_PROG, 20'h00123, 16'h0f0f);
        chk("early_err", d[1], 1);
        chk("early_wr", nw == 0, 1);
        pg <= 1;
        repeat (20) @(posedge mclk);
        for (int i = 0; i < 4; i++)
        begin
            a = i ? 20'($random(seed)) : 20'hfffff;
            v = i ? 16'($random(seed)) : 16'h0000;
            prg(a, v);
        end
        op(fsc_pkg::OP_PROG, 20'h40010, 16'h1234);
        op(fsc_pkg::OP_SUSPEND, 20'h00000, 16'h0000);
        chk("susp_len", n >= fsc_pkg::SUSP_PROG_CYC / 2, 1);
        chk("susp_cmd", {ld[7:0], 8'(nw - m)}, 16'hb001);
        op(fsc_pkg::OP_READ, 20'h80020, 16'h0000);
        rd(fsc_pkg::REG_RDATA);
        chk("susp_rd", d[15:0], 16'h0020 ^ 16'hc3a5);
        op(fsc_pkg::OP_RESUME, 20'h00000, 16'h0000);
        chk("resume", {ld[7:0], 8'(nw - m)}, 16'h3001);
        pol(20'h40010);
        op(fsc_pkg::OP_READ, 20'h40010, 16'h0000);
        rd(fsc_pkg::REG_RDATA);
        chk("resumed", d[15:0], 16'h1234 & (16'h0010 ^ 16'hc3a5));
        for (int k = 0; k < 2; k++)
        begin
            op(fsc_pkg::OP_SEC_STATUS, 20'h00000, 16'h0000);
            chk("ident", d[2], 1);
            rd(fsc_pkg::REG_RDATA);
            chk("lock_flag", d[1], k == 0);
            op(fsc_pkg::OP_IDENT_EXIT, 20'h00000, 16'h0000);
            chk("exit", {ld[7:0], 7'h00, d[2]}, 16'hf000);
            if (k == 0) op(fsc_pkg::OP_SEC_LOCK, 20'h00000, 16'h0000);
            if (k == 0) chk("lock", {la[11:0], ld[1]}, 13'h0100);
        end
        op(fsc_pkg::OP_SEC_PROG, 20'h00088, 16'h5a5a);
        chk("sec_ref", {d[1], nw == m}, 2'b11);
        for (int k = 0; k < 2; k++)
        begin
            if (k == 1) op(fsc_pkg::OP_IDENT_ENTRY, 20'h00000, 16'h0000);
            op(fsc_pkg::OP_CFI, 20'h00000, 16'h0000);
            chk("cfi", {d[3], la[11:0], ld[7:0]}, 21'h105598);
            op(fsc_pkg::OP_IDENT_EXIT, 20'h00000, 16'h0000);
            chk("cfi_exit", d[3], 0);
        end
        end_of_test();
    end
endmodule
